// ===== core/pldu_lock_detect.sv
// pll digital lock detector with pin muxing and wishbone registers
//
// Functional notes
// - Reference and feedback dividers each get a 3-bit delay code (~1 ns).
// - The lock indication can be muxed onto lock, status and monitor pins.
// - Detector cycle is in-lock only when its edge gap is below lock window.
// - The unlock window is always wider than the lock window.
// - Lock asserts after a programmable run of in-window cycles (2-bit set).
// - Once locked, one cycle beyond the unlock window clears the lock.
// - Windows depend on range bit, antibacklash setting and counter setting.
// - Current-source mode is entered via the 6-bit lock pin select.
// - In current-source mode the pin sources while locked, else grounds.
// - The pin comparator goes to monitor or status pin, either polarity.
// - Analog lock output is n-channel (low pulses) or p-channel (high).
// - Counter setting zero needs five in-window cycles.
// - The disable bit holds the lock indication off.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

module pldu_lock_detect (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ref_edge_i,
  input  wire logic        fb_edge_i,
  input  wire logic        ld_cmp_i,
  output logic      [2:0]  ref_delay_o,
  output logic      [2:0]  fb_delay_o,
  output logic             lock_indicator_pin_o,
  output logic             lock_indicator_pin_oe_o,
  output logic             lock_isrc_o,
  output logic             status_pin_o,
  output logic             reference_monitor_pin_o,
  output logic             digital_lock_indication_o
);

  pldu_pkg::pldu_state_s q;
  pldu_pkg::pldu_state_s d;

  logic [7:0] lock_win;
  logic [7:0] unl_win;
  logic [7:0] need;
  logic       evt_in;
  logic       evt_out;
  logic       evt_mid;
  logic       edge_done;
  logic       wr;
  logic       analog_lock_pulse_output;

  function automatic logic mon_mux(input logic [5:0] sel,
                                   input logic       digital_lock_indication,
                                   input logic       cmp);
    logic r;
    r = 1'b0;
    case (sel)
      pldu_pkg::MON_DLD:    r = digital_lock_indication;
      pldu_pkg::MON_CMP_HI: r = cmp;
      pldu_pkg::MON_CMP_LO: r = ~cmp;
      default:              r = 1'b0;
    endcase
    return r;
  endfunction

  // window sizes from range, antibacklash and counter settings
  always_comb begin
    lock_win = q.cfg.win_rng ? pldu_pkg::LOCK_BASE_LO
                             : pldu_pkg::LOCK_BASE_HI;
    lock_win = lock_win + {6'h00, q.cfg.abp} + {6'h00, q.cfg.cnt_sel};
    unl_win  = lock_win + (q.cfg.win_rng ? pldu_pkg::UNL_EXTRA_LO
                                         : pldu_pkg::UNL_EXTRA_HI);
    case (q.cfg.cnt_sel)
      2'h0:    need = pldu_pkg::RUN_NEED_0;
      2'h1:    need = pldu_pkg::RUN_NEED_1;
      2'h2:    need = pldu_pkg::RUN_NEED_2;
      default: need = pldu_pkg::RUN_NEED_3;
    endcase
  end

  // a write lands on the edge at which the master sees ack
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0];

  always_comb begin
    d         = q;
    d.ack     = 1'b0;
    evt_in    = 1'b0;
    evt_out   = 1'b0;
    evt_mid   = 1'b0;
    edge_done = 1'b0;

    // phase gap measurement between the two detector inputs
    case (q.ph)
      pldu_pkg::ST_IDLE: begin
        d.gap = 8'h01;
        if (ref_edge_i && fb_edge_i) begin
          edge_done = 1'b1;
          d.gap     = 8'h00;
        end else if (ref_edge_i) begin
          d.ph = pldu_pkg::ST_WAIT_FB;
        end else if (fb_edge_i) begin
          d.ph = pldu_pkg::ST_WAIT_REF;
        end
      end
      pldu_pkg::ST_WAIT_FB, pldu_pkg::ST_WAIT_REF: begin
        if ((q.ph == pldu_pkg::ST_WAIT_FB) ? fb_edge_i : ref_edge_i) begin
          edge_done = 1'b1;
          d.ph      = pldu_pkg::ST_IDLE;
        end else if (q.gap > unl_win) begin
          evt_out = 1'b1;
          d.ph    = pldu_pkg::ST_IDLE;
        end else begin
          d.gap = q.gap + 8'h01;
        end
      end
      default: begin
        d.ph = pldu_pkg::ST_IDLE;
      end
    endcase

    if (edge_done) begin
      if (q.ph == pldu_pkg::ST_IDLE) begin
        evt_in = 1'b1;
      end else if (q.gap < lock_win) begin
        evt_in = 1'b1;
      end else if (q.gap > unl_win) begin
        evt_out = 1'b1;
      end else begin
        evt_mid = 1'b1;
      end
    end

    // lock qualification
    if (q.cfg.dis) begin
      d.digital_lock_indication = 1'b0;
      d.run = 8'h00;
    end else if (evt_in) begin
      if (q.run != need) begin
        d.run = q.run + 8'h01;
      end
      if (q.run + 8'h01 >= need) begin
        d.digital_lock_indication = 1'b1;
      end
    end else if (evt_out) begin
      d.digital_lock_indication = 1'b0;
      d.run = 8'h00;
    end else if (evt_mid) begin
      d.run = 8'h00;
    end

    // register writes
    if (wr) begin
      case (wb_adr_i[7:2])
        pldu_pkg::IDX_ABP_STAT: begin
          d.cfg.abp      = wb_dat_i[pldu_pkg::ABP_LSB +: 2];
          d.cfg.stat_sel = wb_dat_i[pldu_pkg::STSEL_LSB +: 6];
        end
        pldu_pkg::IDX_LOCK_CTL: begin
          d.cfg.cnt_sel = wb_dat_i[pldu_pkg::CNT_LSB +: 2];
          d.cfg.win_rng = wb_dat_i[pldu_pkg::RNG_BIT];
          d.cfg.dis     = wb_dat_i[pldu_pkg::DIS_BIT];
        end
        pldu_pkg::IDX_DELAY: begin
          d.cfg.rdly = wb_dat_i[pldu_pkg::RDLY_LSB +: 3];
          d.cfg.ndly = wb_dat_i[pldu_pkg::NDLY_LSB +: 3];
        end
        pldu_pkg::IDX_LD_SEL: begin
          d.cfg.ld_sel = wb_dat_i[pldu_pkg::LDSEL_LSB +: 6];
        end
        pldu_pkg::IDX_RM_SEL: begin
          d.cfg.rm_sel = wb_dat_i[pldu_pkg::RMSEL_LSB +: 5];
        end
        default: begin
          d.cfg = q.cfg;
        end
      endcase
    end

    // bus answer: one cycle after the request, unmapped reads give zero
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      d.dat = 32'h0000_0000;
      if (!wb_we_i) begin
        case (wb_adr_i[7:2])
          pldu_pkg::IDX_ABP_STAT: begin
            d.dat[7:0] = {q.cfg.stat_sel, q.cfg.abp};
          end
          pldu_pkg::IDX_LOCK_CTL: begin
            d.dat[7:0] = {1'b0, q.cfg.cnt_sel, q.cfg.win_rng, q.cfg.dis,
                          3'h0};
          end
          pldu_pkg::IDX_DELAY: begin
            d.dat[7:0] = {2'h0, q.cfg.rdly, q.cfg.ndly};
          end
          pldu_pkg::IDX_LD_SEL: begin
            d.dat[7:0] = {2'h0, q.cfg.ld_sel};
          end
          pldu_pkg::IDX_RM_SEL: begin
            d.dat[7:0] = {3'h0, q.cfg.rm_sel};
          end
          pldu_pkg::IDX_STATUS: begin
            d.dat[pldu_pkg::ST_DLD_BIT]      = q.digital_lock_indication;
            d.dat[pldu_pkg::ST_CMP_BIT]      = ld_cmp_i;
            d.dat[pldu_pkg::ST_RUN_LSB +: 8] = q.run;
          end
          default: begin
            d.dat = 32'h0000_0000;
          end
        endcase
      end
    end

    // analog pulse is high while a phase error is being measured
    analog_lock_pulse_output = (d.ph != pldu_pkg::ST_IDLE);

    // lock pin driver
    d.ld_isrc = 1'b0;
    case (d.cfg.ld_sel)
      pldu_pkg::LD_DLD: begin
        d.ld    = d.digital_lock_indication;
        d.ld_oe = 1'b1;
      end
      pldu_pkg::LD_NCH: begin
        d.ld    = 1'b0;
        d.ld_oe = analog_lock_pulse_output;
      end
      pldu_pkg::LD_PCH: begin
        d.ld    = 1'b1;
        d.ld_oe = analog_lock_pulse_output;
      end
      pldu_pkg::LD_ISRC: begin
        d.ld_isrc = d.digital_lock_indication;
        d.ld      = 1'b0;
        d.ld_oe   = ~d.digital_lock_indication;
      end
      default: begin
        d.ld    = 1'b0;
        d.ld_oe = 1'b1;
      end
    endcase

    d.reference_monitor_pin = mon_mux({1'b0, d.cfg.rm_sel}, d.digital_lock_indication, ld_cmp_i);
    d.status = mon_mux(d.cfg.stat_sel, d.digital_lock_indication, ld_cmp_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.cfg.abp  <= pldu_pkg::ABP_STAT_RST[1:0];
      q.cfg.stat_sel <= pldu_pkg::ABP_STAT_RST[7:2];
      q.cfg.cnt_sel  <= pldu_pkg::LOCK_CTL_RST[6:5];
      q.cfg.win_rng  <= pldu_pkg::LOCK_CTL_RST[4];
      q.cfg.dis      <= pldu_pkg::LOCK_CTL_RST[3];
      q.cfg.rdly     <= pldu_pkg::DELAY_RST[5:3];
      q.cfg.ndly     <= pldu_pkg::DELAY_RST[2:0];
      q.cfg.ld_sel   <= pldu_pkg::LD_SEL_RST[5:0];
      q.cfg.rm_sel   <= pldu_pkg::RM_SEL_RST[4:0];
      q.ph       <= pldu_pkg::ST_IDLE;
      q.digital_lock_indication      <= 1'b0;
      q.run      <= 8'h00;
      q.ld_oe    <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign wb_dat_o                  = q.dat;
  assign wb_ack_o                  = q.ack;
  assign ref_delay_o               = q.cfg.rdly;
  assign fb_delay_o                = q.cfg.ndly;
  assign lock_indicator_pin_o      = q.ld;
  assign lock_indicator_pin_oe_o   = q.ld_oe;
  assign lock_isrc_o               = q.ld_isrc;
  assign status_pin_o              = q.status;
  assign reference_monitor_pin_o   = q.reference_monitor_pin;
  assign digital_lock_indication_o = q.digital_lock_indication;

  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ack && ce_i |=> !q.ack)
    else $error("ack held longer than one cycle");

  a_delay_code_write: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr && ce_i && wb_adr_i[7:2] == pldu_pkg::IDX_DELAY
    |=> ref_delay_o == $past(wb_dat_i[5:3])
        && fb_delay_o == $past(wb_dat_i[2:0]))
    else $error("delay code not taken from write");

  a_unlock_wider: assert property (@(posedge clk_i) disable iff (rst_i)
    unl_win > lock_win)
    else $error("unlock window not wider than lock window");

  a_lock_after_run: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.digital_lock_indication) |-> $past(q.run) + 8'h01 >= $past(need) && $past(evt_in))
    else $error("lock rose without enough in-window cycles");

  a_five_cycle_lock: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $rose(q.digital_lock_indication) && $past(q.cfg.cnt_sel) == 2'h0 |-> $past(q.run) == 8'h04)
    else $error("counter setting zero did not need five cycles");

  a_single_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && q.digital_lock_indication && evt_out |=> !q.digital_lock_indication)
    else $error("lock survived an out-of-window cycle");

  a_disable_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && q.cfg.dis |=> !q.digital_lock_indication && q.run == 8'h00)
    else $error("lock active while disabled");

  a_reset_clears: assert property (@(posedge clk_i)
    rst_i |=> !q.digital_lock_indication && q.run == 8'h00)
    else $error("lock state not cleared by reset");

  a_isrc_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    q.cfg.ld_sel == pldu_pkg::LD_ISRC
    |-> lock_isrc_o == q.digital_lock_indication && lock_indicator_pin_oe_o == !q.digital_lock_indication)
    else $error("current source pin does not follow lock");

  a_nch_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    q.cfg.ld_sel == pldu_pkg::LD_NCH |-> !lock_indicator_pin_o)
    else $error("n-channel output drives high");

  a_cmp_low_mon: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && d.cfg.rm_sel == pldu_pkg::MON_CMP_LO[4:0]
    |=> reference_monitor_pin_o == !$past(ld_cmp_i))
    else $error("monitor pin not inverted comparator");

  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");

  a_lock_pin_mux: assert property (@(posedge clk_i) disable iff (rst_i)
    q.cfg.ld_sel == pldu_pkg::LD_DLD |-> lock_indicator_pin_o == q.digital_lock_indication)
    else $error("lock pin does not carry the lock flag");

  a_status_mux: assert property (@(posedge clk_i) disable iff (rst_i)
    q.cfg.stat_sel == pldu_pkg::MON_DLD |-> status_pin_o == q.digital_lock_indication)
    else $error("status pin does not carry the lock flag");

endmodule

// ===== pkg/pldu_pkg.sv
// shared constants and types for the pll lock detect unit
package pldu_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_ABP_STAT = 6'h17;
  localparam logic [5:0] IDX_LOCK_CTL = 6'h18;
  localparam logic [5:0] IDX_DELAY    = 6'h19;
  localparam logic [5:0] IDX_LD_SEL   = 6'h1A;
  localparam logic [5:0] IDX_RM_SEL   = 6'h1B;
  localparam logic [5:0] IDX_STATUS   = 6'h1F;

  // field positions
  localparam int ABP_LSB     = 0;
  localparam int STSEL_LSB   = 2;
  localparam int DIS_BIT     = 3;
  localparam int RNG_BIT     = 4;
  localparam int CNT_LSB     = 5;
  localparam int NDLY_LSB    = 0;
  localparam int RDLY_LSB    = 3;
  localparam int LDSEL_LSB   = 0;
  localparam int RMSEL_LSB   = 0;
  localparam int ST_DLD_BIT  = 0;
  localparam int ST_CMP_BIT  = 1;
  localparam int ST_RUN_LSB  = 8;

  // reset values
  localparam logic [7:0] ABP_STAT_RST = 8'h00;
  localparam logic [7:0] LOCK_CTL_RST = 8'h00;
  localparam logic [7:0] DELAY_RST    = 8'h00;
  localparam logic [7:0] LD_SEL_RST   = 8'h00;
  localparam logic [7:0] RM_SEL_RST   = 8'h00;

  // lock pin output select codes
  localparam logic [5:0] LD_DLD  = 6'h00;
  localparam logic [5:0] LD_NCH  = 6'h01;
  localparam logic [5:0] LD_PCH  = 6'h02;
  localparam logic [5:0] LD_ISRC = 6'h04;

  // monitor pin (status / reference monitor) select codes
  localparam logic [5:0] MON_DLD    = 6'h01;
  localparam logic [5:0] MON_CMP_HI = 6'h02;
  localparam logic [5:0] MON_CMP_LO = 6'h03;

  // window timing in 10 ns clock cycles
  localparam logic [7:0] LOCK_BASE_HI = 8'h04;
  localparam logic [7:0] LOCK_BASE_LO = 8'h01;
  localparam logic [7:0] UNL_EXTRA_HI = 8'h06;
  localparam logic [7:0] UNL_EXTRA_LO = 8'h02;

  // consecutive in-window cycles needed per counter setting
  localparam logic [7:0] RUN_NEED_0 = 8'h05;
  localparam logic [7:0] RUN_NEED_1 = 8'h10;
  localparam logic [7:0] RUN_NEED_2 = 8'h40;
  localparam logic [7:0] RUN_NEED_3 = 8'hFF;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_WAIT_FB  = 2'b01,
    ST_WAIT_REF = 2'b10
  } pldu_phase_e;

  typedef struct packed {
    logic [1:0] abp;
    logic [5:0] stat_sel;
    logic [1:0] cnt_sel;
    logic       win_rng;
    logic       dis;
    logic [2:0] rdly;
    logic [2:0] ndly;
    logic [5:0] ld_sel;
    logic [4:0] rm_sel;
  } pldu_cfg_s;

  typedef struct packed {
    pldu_cfg_s   cfg;
    pldu_phase_e ph;
    logic [7:0]  gap;
    logic [7:0]  run;
    logic        digital_lock_indication;
    logic        ld;
    logic        ld_oe;
    logic        ld_isrc;
    logic        reference_monitor_pin;
    logic        status;
    logic        ack;
    logic [31:0] dat;
  } pldu_state_s;

endpackage

// ===== sim/pldu_cap_model.sv
// behavioural model of the lock pin capacitor and its comparator
`timescale 1ns/1ps

module pldu_cap_model #(
  parameter int CHARGE_CYC = 20
) (
  input  wire logic clk_i,
  input  wire logic isrc_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  output logic      cmp_o
);
  int level;

  always @(posedge clk_i) begin
    if (pin_oe_i && !pin_i) begin
      level <= 0;
    end else if (isrc_i && level < CHARGE_CYC) begin
      level <= level + 1;
    end
    cmp_o <= (level >= CHARGE_CYC);
  end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the pll lock detect unit
`timescale 1ns/1ps

module tb_top;
  logic        clk_i, rst_i, cyc, stb, we, ref_e, fb_e, cmp, ack;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, dat_o;
  logic [2:0]  rdly, fdly;
  logic        ld, ld_oe, isrc, stat, rmon, digital_lock_indication;
  int          failures, checked, lw, uw, need, run, lock, v, dis, oe_cnt;
  logic [5:0]  idx_q [7] = '{6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1F, 6'h3F};

  pldu_lock_detect u_pldu_lock_detect (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ref_edge_i(ref_e), .fb_edge_i(fb_e), .ld_cmp_i(cmp),
    .ref_delay_o(rdly), .fb_delay_o(fdly), .lock_indicator_pin_o(ld),
    .lock_indicator_pin_oe_o(ld_oe), .lock_isrc_o(isrc),
    .status_pin_o(stat), .reference_monitor_pin_o(rmon),
    .digital_lock_indication_o(digital_lock_indication));

  pldu_cap_model u_pldu_cap_model (
    .clk_i(clk_i), .isrc_i(isrc), .pin_i(ld), .pin_oe_i(ld_oe),
    .cmp_o(cmp));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // counts the edges at which the lock pin driver is enabled
  always @(posedge clk_i) oe_cnt <= oe_cnt + int'(ld_oe);

  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // one classic cycle; read data lands in rdat
  task automatic wb(input logic w, input logic [5:0] idx,
                    input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w;
    adr <= {idx, 2'b00}; wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) begin
      failures++;
      $display("unexpected at %0t: bus answer missing", $time);
      report_and_stop();
    end
    @(posedge clk_i);
  endtask

  // reference edge, then feedback edge gap cycles later; gap < 0: none
  task automatic phase_frequency_detector(input int gap);
    ref_e <= 1'b1; fb_e <= (gap == 0);
    @(posedge clk_i);
    ref_e <= 1'b0; fb_e <= 1'b0;
    if (gap > 0) begin
      repeat (gap - 1) @(posedge clk_i);
      fb_e <= 1'b1;
      @(posedge clk_i);
      fb_e <= 1'b0;
    end
    repeat (24) @(posedge clk_i);
  endtask

  task automatic step(input int gap);
    phase_frequency_detector(gap);
    if (gap >= 0 && gap < lw) begin
      run++;
      if (run >= need) lock = 1;
    end else begin
      run = 0;
      if (gap < 0 || gap > uw) lock = 0;
    end
    if (dis != 0) begin
      run = 0;
      lock = 0;
    end
    chk(16'(digital_lock_indication), 16'(lock), "lock flag");
  endtask

  task automatic cfg(input int abp, input int cnt, input int rng,
                     input logic [5:0] ssel);
    wb(1'b1, pldu_pkg::IDX_ABP_STAT, {ssel, 2'(abp)});
    wb(1'b1, pldu_pkg::IDX_LOCK_CTL, {1'b0, 2'(cnt), 1'(rng), 4'h0});
    lw = (rng ? 1 : 4) + abp + cnt;
    uw = lw + (rng ? 2 : 6);
    need = cnt == 0 ? 5 : cnt == 1 ? 16 : cnt == 2 ? 64 : 255;
  endtask

  task automatic done_test(input string n);
    $display("test %s finished, failures so far %0d", n, failures);
  endtask

  initial begin
    failures = 0; checked = 0; run = 0; lock = 0; dis = 0;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
    ref_e = 1'b0; fb_e = 1'b0; rst_i = 1'b1;
    void'($urandom(32'hB0FB));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(16'({digital_lock_indication, ld, ld_oe, isrc, stat, rmon}), 16'h0008, "reset pin");
    foreach (idx_q[i]) begin
      wb(1'b0, idx_q[i], 8'h00);
      chk(rdat[15:0], 16'h0000, "reset register");
    end
    wb(1'b1, 6'h3F, 8'hA5);
    wb(1'b0, 6'h3F, 8'h00);
    chk(rdat[15:0], 16'h0000, "unmapped read");
    done_test("reset");

    v = $urandom_range(63);
    wb(1'b1, pldu_pkg::IDX_DELAY, 8'(v));
    wb(1'b0, pldu_pkg::IDX_DELAY, 8'h00);
    chk(16'({rdly, fdly}), 16'(v), "delay codes");
    chk(rdat[15:0], 16'(v), "delay readback");
    done_test("delay");

    wb(1'b1, pldu_pkg::IDX_RM_SEL, {2'b00, pldu_pkg::MON_DLD});
    cfg($urandom_range(3), 0, 0, pldu_pkg::MON_DLD);
    for (int i = 0; i < 5; i++) begin
      step($urandom_range(lw - 1));
      if (i == 3) begin
        wb(1'b0, pldu_pkg::IDX_STATUS, 8'h00);
        chk(16'(rdat[15:8]), 16'h0004, "run count");
      end
    end
    chk(16'(lock), 16'h0001, "lock after five");
    chk(16'({ld, ld_oe, stat, rmon}), 16'h000F, "lock on pins");
    step(lw);
    step(uw);
    step(-1);
    chk(16'({ld, stat, rmon}), 16'h0000, "unlock on pins");
    done_test("window");

    cfg($urandom_range(3), 1, 1, pldu_pkg::MON_CMP_HI);
    for (int i = 0; i < 16; i++) step($urandom_range(lw - 1));
    wb(1'b1, pldu_pkg::IDX_LD_SEL, {2'b00, pldu_pkg::LD_ISRC});
    chk(16'({isrc, ld_oe}), 16'h0002, "source on");
    repeat (40) @(posedge clk_i);
    wb(1'b1, pldu_pkg::IDX_RM_SEL, {2'b00, pldu_pkg::MON_CMP_LO});
    chk(16'({stat, rmon}), 16'h0002, "comparator high");
    step(-1);
    chk(16'({isrc, ld, ld_oe}), 16'h0001, "source off");
    chk(16'({stat, rmon}), 16'h0001, "comparator low");
    done_test("current source");

    cfg(0, 0, 0, pldu_pkg::MON_DLD);
    for (int i = 0; i < 5; i++) step($urandom_range(lw - 1));
    wb(1'b1, pldu_pkg::IDX_LOCK_CTL, 8'h08);
    dis = 1;
    lock = 0;
    run = 0;
    @(posedge clk_i);
    chk(16'(digital_lock_indication), 16'h0000, "disabled");
    step(1);
    wb(1'b1, pldu_pkg::IDX_LOCK_CTL, 8'h00);
    dis = 0;
    done_test("disable");

    for (int k = 1; k < 3; k++) begin
      wb(1'b1, pldu_pkg::IDX_LD_SEL, 8'(k));
      v = oe_cnt;
      step(2);
      chk(16'({ld, ld_oe}), 16'({k == 2, 1'b0}), "analog idle");
      chk(16'(oe_cnt - v), 16'h0002, "analog pulse");
    end
    done_test("analog");
    report_and_stop();
  end
endmodule
